// *** evi_ctrl.sv ***
/*
 * Event and software interrupt source table with priority arbiter.
 * Assumes peripheral flags and core level come from logic on clk,
 * and a single-cycle register port with read data one cycle later.
 */
// The strobed register port and the address map were chosen for this implementation.
// Overview of operation
// - External 0: rank 2, vector 0080, LVL0[2:0]
// - Timer 0: rank 3, vector 0084, LVL0[6:4]
// - External 1: rank 4, vector 0088, LVL1[2:0]
// - Timer 1: rank 5, vector 008C, LVL1[6:4]
// - Timer 2, either flag: rank 6, 0090
// - Serial 0 rx: rank 7, vector 00A0
// - Serial 0 tx: rank 8, vector 00A4
// - Serial 1 rx: rank 9, vector 00A8
// - Serial 1 tx: lowest rank 10, 00AC
// - Software one: fixed level 1, 0100
// - Software two: fixed level 2, 0104
// - Software three: fixed level 3, 0108
// - Software four: fixed level 4, 010C
// - Software five: fixed level 5, 0110
// - Software six: fixed level 6, 0114
// - Software seven: fixed level 7, 0118
// - Global gate plus own enable per event
// - Nonzero 3-bit field gets top bit set
// - Equal priority: lower rank served first
`timescale 1ns/1ps
module evi_ctrl (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  // Peripheral flags
  input  wire logic       ext0_flag,
  input  wire logic       timer0_overflow_flag,
  input  wire logic       ext1_flag,
  input  wire logic       timer1_overflow_flag,
  input  wire logic       timer2_overflow_flag,
  input  wire logic       timer2_external_flag,
  input  wire logic       uart0_rx_flag,
  input  wire logic       uart0_tx_flag,
  input  wire logic       uart1_rx_flag,
  input  wire logic       uart1_tx_flag,
  // Core side
  input  wire logic [3:0] core_level,
  output logic            irq_req,
  output logic     [15:0] irq_vector,
  output logic      [3:0] irq_level
);

  // ****************************************
  // Effective priority of an event field
  // ****************************************
  function automatic logic [3:0] evi_eff(input logic [2:0] f);
    evi_eff = (f == 3'h0) ? 4'h0 : {1'b1, f};
  endfunction

  // Source index of a vector slot base
  function automatic logic [3:0] evi_slot(input logic [15:0] v);
    if (v[8]) begin
      evi_slot = 4'h9 + v[5:2];
    end else if (v[5]) begin
      evi_slot = 4'h5 + {2'h0, v[3:2]};
    end else begin
      evi_slot = {1'b0, v[4:2]};
    end
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] int_enable_low_reg;
  logic [7:0] int_enable_high_reg;
  logic [7:0] lvl_r   [5];
  logic [7:0] swe_r;
  logic [7:0] swr_r;
  logic [7:0] enl_nxt;
  logic [7:0] enh_nxt;
  logic [7:0] lvl_nxt [5];
  logic [7:0] swe_nxt;
  logic [7:0] swr_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;

  always_comb begin
    enl_nxt = int_enable_low_reg;
    enh_nxt = int_enable_high_reg;
    lvl_nxt = lvl_r;
    swe_nxt = swe_r;
    swr_nxt = swr_r;
    rd_nxt  = rd_r;
    if (reg_we) begin
      case (reg_addr)
        evi_pkg::OFF_ENL:  enl_nxt    = reg_wdata & evi_pkg::ENL_MASK;
        evi_pkg::OFF_ENH:  enh_nxt    = reg_wdata & evi_pkg::ENH_MASK;
        evi_pkg::OFF_LVL0: lvl_nxt[0] = reg_wdata & evi_pkg::LVL_MASK;
        evi_pkg::OFF_LVL1: lvl_nxt[1] = reg_wdata & evi_pkg::LVL_MASK;
        evi_pkg::OFF_LVL2: lvl_nxt[2] = reg_wdata & evi_pkg::LVL2_MASK;
        evi_pkg::OFF_LVL4: lvl_nxt[3] = reg_wdata & evi_pkg::LVL_MASK;
        evi_pkg::OFF_LVL5: lvl_nxt[4] = reg_wdata & evi_pkg::LVL_MASK;
        evi_pkg::OFF_SWE:  swe_nxt    = reg_wdata & evi_pkg::SW_MASK;
        evi_pkg::OFF_SWR:  swr_nxt    = reg_wdata & evi_pkg::SW_MASK;
        default: ;
      endcase
    end
    if (reg_re) begin
      case (reg_addr)
        evi_pkg::OFF_ENL:  rd_nxt = int_enable_low_reg;
        evi_pkg::OFF_ENH:  rd_nxt = int_enable_high_reg;
        evi_pkg::OFF_LVL0: rd_nxt = lvl_r[0];
        evi_pkg::OFF_LVL1: rd_nxt = lvl_r[1];
        evi_pkg::OFF_LVL2: rd_nxt = lvl_r[2];
        evi_pkg::OFF_LVL4: rd_nxt = lvl_r[3];
        evi_pkg::OFF_LVL5: rd_nxt = lvl_r[4];
        evi_pkg::OFF_SWE:  rd_nxt = swe_r;
        evi_pkg::OFF_SWR:  rd_nxt = swr_r;
        evi_pkg::OFF_STAT: rd_nxt = {irq_req, 3'h0, irq_level};
        default:           rd_nxt = 8'h00;
      endcase
    end else begin
      rd_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_enable_low_reg  <= evi_pkg::RST_ENABLE;
      int_enable_high_reg <= evi_pkg::RST_ENABLE;
      lvl_r               <= '{default: evi_pkg::RST_LEVEL};
      swe_r               <= evi_pkg::RST_SOFT;
      swr_r               <= evi_pkg::RST_SOFT;
      rd_r                <= 8'h00;
    end else begin
      int_enable_low_reg  <= enl_nxt;
      int_enable_high_reg <= enh_nxt;
      lvl_r               <= lvl_nxt;
      swe_r               <= swe_nxt;
      swr_r               <= swr_nxt;
      rd_r                <= rd_nxt;
    end
  end

  assign reg_rdata = rd_r;

  // ****************************************
  // Source requests and levels
  // ****************************************
  logic                 global_event_gate;
  logic [8:0]           evt_flag;
  logic [8:0]           evt_en;
  logic [15:0]          req;
  logic [3:0]           elvl [evi_pkg::NUM_SRC];

  assign global_event_gate = int_enable_low_reg[evi_pkg::GATE_BIT];
  assign evt_flag = {uart1_tx_flag, uart1_rx_flag, uart0_tx_flag,
                     uart0_rx_flag,
                     timer2_overflow_flag | timer2_external_flag,
                     timer1_overflow_flag, ext1_flag,
                     timer0_overflow_flag, ext0_flag};
  assign evt_en = {int_enable_high_reg[3:0], int_enable_low_reg[4:0]};

  generate
    for (genvar e = 0; e < evi_pkg::NUM_EVT; e++) begin : g_evt
      // Event gated by own enable and common gate
      assign req[e] = evt_flag[e] & evt_en[e] & global_event_gate;
      // Field picked from its level register
      assign elvl[e] = evi_eff(
        lvl_r[evi_pkg::LVL_REG[e]][evi_pkg::LVL_SH[e] +: 3]);
    end
    for (genvar s = 1; s < 8; s++) begin : g_sw
      assign req[evi_pkg::NUM_EVT + s - 1] = swr_r[s] & swe_r[s];
      assign elvl[evi_pkg::NUM_EVT + s - 1] = 4'(s);
    end
  endgenerate

  // ****************************************
  // Arbiter and core outputs
  // ****************************************
  logic        cand [evi_pkg::NUM_SRC];
  logic        req_r;
  logic        req_nxt;
  logic [15:0] vec_r;
  logic [15:0] vec_nxt;
  logic [3:0]  lvl_o_r;
  logic [3:0]  lvl_o_nxt;

  always_comb begin
    req_nxt   = 1'b0;
    vec_nxt   = 16'h0000;
    lvl_o_nxt = 4'h0;
    for (int i = 0; i < evi_pkg::NUM_SRC; i++) begin
      cand[i] = req[i] && (elvl[i] > core_level);
      // Strictly greater keeps the lower rank on a tie
      if (cand[i] && (!req_nxt || elvl[i] > lvl_o_nxt)) begin
        req_nxt   = 1'b1;
        vec_nxt   = evi_pkg::VEC[i];
        lvl_o_nxt = elvl[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_r   <= 1'b0;
      vec_r   <= 16'h0000;
      lvl_o_r <= 4'h0;
    end else begin
      req_r   <= req_nxt;
      vec_r   <= vec_nxt;
      lvl_o_r <= lvl_o_nxt;
    end
  end

  assign irq_req    = req_r;
  assign irq_vector = vec_r;
  assign irq_level  = lvl_o_r;

  // ****************************************
  // Check helpers
  // ****************************************
  logic [15:0] req_q_r;
  logic [15:0] req_q_nxt;

  // Requests of the cycle the outputs came from
  always_comb begin
    req_q_nxt = req;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_q_r <= 16'h0000;
    end else begin
      req_q_r <= req_q_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ext0_top;
    ext0_flag && int_enable_low_reg[0] && global_event_gate
      && lvl_r[0][2:0] == 3'h7 && core_level == 4'h0;
  endsequence

  chk_ext0_vector: assert property (
    s_ext0_top |=> irq_req && irq_vector == 16'h0080 && irq_level == 4'hF)
    else $error("ext0 at top level not vectored to 0080");

  chk_event_gate: assert property (
    irq_req && irq_level[3] |-> $past(global_event_gate))
    else $error("event vectored while global gate closed");

  chk_above_core: assert property (
    irq_req |-> irq_level > $past(core_level))
    else $error("request not above core level");

  chk_event_top_bit: assert property (
    irq_req && irq_vector < 16'h0100 |-> irq_level[3])
    else $error("event level lacks top bit");

  chk_sw7_level: assert property (
    irq_req && irq_vector == 16'h0118 |-> irq_level == 4'h7
      && $past(swr_r[7] && swe_r[7]))
    else $error("software seven level or cause wrong");

  chk_t2_either: assert property (
    timer2_external_flag && !timer2_overflow_flag && int_enable_low_reg[4]
      && global_event_gate && lvl_r[2][2:0] != 3'h0 && core_level == 4'h0
      |=> irq_req)
    else $error("timer2 external flag not requested");

  chk_tie_rank: assert property (
    irq_req && irq_vector == 16'h0084
      |-> !$past(cand[0] && elvl[0] >= elvl[1]))
    else $error("timer0 beat ext0 at equal level");

  chk_u1tx_cause: assert property (
    irq_req && irq_vector == 16'h00AC
      |-> $past(uart1_tx_flag && int_enable_high_reg[3])) 
    else $error("serial one tx vector without cause");

  chk_reset_clear: assert property (
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> int_enable_low_reg == 8'h00 && swr_r == 8'h00
      && lvl_r[0] == 8'h00 && !irq_req)
    else $error("reset left state set");

  chk_read_data: assert property (
    reg_re && reg_addr == evi_pkg::OFF_ENL
      |=> reg_rdata == $past(int_enable_low_reg))
    else $error("enable register read back wrong");

  chk_winner_cause: assert property (
    irq_req |-> req_q_r[evi_slot(irq_vector)])
    else $error("vector given for a source not requesting");

  chk_soft_level: assert property (
    irq_req && irq_vector[8] |-> irq_level == evi_slot(irq_vector) - 4'h8)
    else $error("software level does not match its slot");

  chk_idle_outputs: assert property (
    !irq_req |-> irq_vector == 16'h0000 && irq_level == 4'h0)
    else $error("vector or level shown without request");

  chk_event_nonzero: assert property (
    irq_req && !irq_vector[8] |-> irq_level[3] && irq_level[2:0] != 3'h0)
    else $error("event presented with a zero field");

  chk_sw_fire: assert property (
    swr_r[1] && swe_r[1] && core_level == 4'h0 |=> irq_req)
    else $error("enabled software one not requested");

  chk_t0_cause: assert property (
    irq_req && irq_vector == 16'h0084
      |-> $past(timer0_overflow_flag && int_enable_low_reg[1]))
    else $error("timer zero vector without cause");

  chk_ext1_cause: assert property (
    irq_req && irq_vector == 16'h0088
      |-> $past(ext1_flag && int_enable_low_reg[2]))
    else $error("external one vector without cause");

  chk_t1_cause: assert property (
    irq_req && irq_vector == 16'h008C
      |-> $past(timer1_overflow_flag && int_enable_low_reg[3]))
    else $error("timer one vector without cause");

  chk_u0rx_cause: assert property (
    irq_req && irq_vector == 16'h00A0
      |-> $past(uart0_rx_flag && int_enable_high_reg[0]))
    else $error("serial zero rx vector without cause");

  chk_u0tx_cause: assert property (
    irq_req && irq_vector == 16'h00A4
      |-> $past(uart0_tx_flag && int_enable_high_reg[1]))
    else $error("serial zero tx vector without cause");

  chk_u1rx_cause: assert property (
    irq_req && irq_vector == 16'h00A8
      |-> $past(uart1_rx_flag && int_enable_high_reg[2]))
    else $error("serial one rx vector without cause");

endmodule // evi_ctrl

// *** evi_pkg.sv ***
/*
 * Constants of the event interrupt vectoring block: register offsets,
 * enable bit positions, reset values, priority field map and vectors.
 * Assumes an 8-bit register port with a 4-bit word address.
 */
package evi_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFF_ENL  = 4'h0;
  localparam logic [3:0] OFF_ENH  = 4'h1;
  localparam logic [3:0] OFF_LVL0 = 4'h2;
  localparam logic [3:0] OFF_LVL1 = 4'h3;
  localparam logic [3:0] OFF_LVL2 = 4'h4;
  localparam logic [3:0] OFF_LVL4 = 4'h5;
  localparam logic [3:0] OFF_LVL5 = 4'h6;
  localparam logic [3:0] OFF_SWE  = 4'h7;
  localparam logic [3:0] OFF_SWR  = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'h9;

  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int         GATE_BIT  = 7;
  localparam logic [7:0] ENL_MASK  = 8'h9F;
  localparam logic [7:0] ENH_MASK  = 8'h0F;
  localparam logic [7:0] LVL_MASK  = 8'h77;
  localparam logic [7:0] LVL2_MASK = 8'h07;
  localparam logic [7:0] SW_MASK   = 8'hFE;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_LEVEL  = 8'h00;
  localparam logic [7:0] RST_SOFT   = 8'h00;

  // ****************************************
  // Sources and priority map
  // ****************************************
  localparam int NUM_EVT = 9;
  localparam int NUM_SRC = 16;
  // Level register index (0..4 = LVL0,1,2,4,5) and field shift per event
  localparam int LVL_REG [NUM_EVT] = '{0, 0, 1, 1, 2, 3, 3, 4, 4};
  localparam int LVL_SH  [NUM_EVT] = '{0, 4, 0, 4, 0, 0, 4, 0, 4};

  // Vector slot base per source, in arbitration order
  localparam logic [15:0] VEC [NUM_SRC] = '{
    16'h0080, 16'h0084, 16'h0088, 16'h008C, 16'h0090,
    16'h00A0, 16'h00A4, 16'h00A8, 16'h00AC,
    16'h0100, 16'h0104, 16'h0108, 16'h010C,
    16'h0110, 16'h0114, 16'h0118};

endpackage

// *** evi_core_model.sv ***
/*
 * Behavioural processor core that takes vectored requests.
 * Assumes the bench steers take latency, taking and return.
 */
`timescale 1ns/1ps
module evi_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Block side
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_level,
  output logic      [3:0] core_level,
  // Bench control
  input  wire logic [1:0] take_lat,
  input  wire logic       take_en,
  input  wire logic       ret
);
  logic [1:0] wait_r;
  logic [1:0] wait_nxt;
  logic [3:0] lvl_r;
  logic [3:0] lvl_nxt;

  // Entry after take_lat cycles of a steady request
  always_comb begin
    wait_nxt = (irq_req && take_en) ? wait_r + 2'h1 : 2'h0;
    lvl_nxt  = ret ? 4'h0 : lvl_r;
    if (irq_req && take_en && wait_r == take_lat) begin
      lvl_nxt  = irq_level;
      wait_nxt = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_r <= 2'h0;
      lvl_r  <= 4'h0;
    end else begin
      wait_r <= wait_nxt;
      lvl_r  <= lvl_nxt;
    end
  end

  assign core_level = lvl_r;
endmodule // evi_core_model

// *** evi_ctrl_bench.sv ***
/*
 * Self-checking bench of evi_ctrl with a core model.
 * Assumes evi_pkg constants and a one-cycle register port.
 */
`timescale 1ns/1ps
module evi_ctrl_bench;
  logic        clk;
  logic        sys_rst;
  logic        reg_we;
  logic        reg_re;
  logic        irq_req;
  logic        take_en;
  logic        ret;
  logic [1:0]  take_lat;
  logic [3:0]  reg_addr;
  logic [3:0]  core_level;
  logic [3:0]  irq_level;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  d;
  logic [9:0]  flg;
  logic [15:0] irq_vector;
  int          n_errors = 0;
  int          compares = 0;
  localparam logic [7:0] MSK [9] = '{8'h9F, 8'h0F, 8'h77, 8'h77, 8'h07, 8'h77, 8'h77,
                                     8'hFE, 8'hFE};

  evi_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .ext0_flag(flg[0]),
    .timer0_overflow_flag(flg[1]), .ext1_flag(flg[2]), .timer1_overflow_flag(flg[3]),
    .timer2_overflow_flag(flg[4]), .timer2_external_flag(flg[9]), .uart0_rx_flag(flg[5]),
    .uart0_tx_flag(flg[6]), .uart1_rx_flag(flg[7]), .uart1_tx_flag(flg[8]),
    .core_level(core_level), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level));
  evi_core_model core (.clk(clk), .sys_rst(sys_rst), .irq_req(irq_req),
    .irq_level(irq_level), .core_level(core_level), .take_lat(take_lat),
    .take_en(take_en), .ret(ret));

  // ****************************************
  // Bus, wait and compare tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic chk_reg(input logic [7:0] exp);
    compares++;
    if (d !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, d, exp);
    end
  endtask
  task automatic chk_irq(input logic r, input logic [15:0] v, input logic [3:0] l);
    compares++;
    if ({irq_req, irq_vector, irq_level} !== {r, v, l}) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, {irq_req, irq_vector, irq_level},
               {r, v, l});
    end
  endtask
  task automatic clr();
    @(posedge clk);
    flg <= 10'h000;
    for (int a = 0; a < 9; a++) wr(4'(a), 8'h00);
    settle();
  endtask
  task automatic ev_on(input int i, input logic [2:0] f);
    wr(4'h0, (i < 5) ? (8'h81 << i) | 8'h80 : 8'h80);
    if (i >= 5) wr(4'h1, 8'h01 << (i - 5));
    wr(evi_pkg::OFF_LVL0 + 4'(evi_pkg::LVL_REG[i]), 8'(f) << evi_pkg::LVL_SH[i]);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    chk_irq(1'b0, 16'h0000, 4'h0);
    for (int a = 0; a < 10; a++) begin
      rd(4'(a));
      if (a < 9) chk_reg(8'h00);
      else chk_reg(8'h87);
      wr(4'(a), 8'hFF);
      rd(4'(a));
      if (a < 9) chk_reg(MSK[a]);
      else chk_reg(8'h87);
    end
    wr(4'hF, 8'hFF);
    rd(4'hF);
    chk_reg(8'h00);
    clr();
  endtask
  task automatic t_events();
    for (int i = 0; i < 9; i++) begin
      ev_on(i, 3'h7);
      flg[i] <= 1'b1;
      settle();
      chk_irq(1'b1, evi_pkg::VEC[i], 4'hF);
      ev_on(i, 3'h0);
      settle();
      chk_irq(1'b0, 16'h0000, 4'h0);
      ev_on(i, 3'h1);
      settle();
      chk_irq(1'b1, evi_pkg::VEC[i], 4'h9);
      clr();
    end
    ev_on(4, 3'h2);
    flg[9] <= 1'b1;
    settle();
    chk_irq(1'b1, 16'h0090, 4'hA);
    clr();
  endtask
  task automatic t_gate();
    ev_on(0, 3'h7);
    flg[0] <= 1'b1;
    wr(4'h0, 8'h01);
    settle();
    chk_irq(1'b0, 16'h0000, 4'h0);
    wr(4'h0, 8'h80);
    settle();
    chk_irq(1'b0, 16'h0000, 4'h0);
    clr();
  endtask
  task automatic t_tie();
    wr(4'h0, 8'h9F);
    wr(4'h1, 8'h0F);
    for (int a = 2; a < 7; a++) wr(4'(a), 8'h33);
    wr(evi_pkg::OFF_SWE, 8'hFE);
    wr(evi_pkg::OFF_SWR, 8'hFE);
    flg <= 10'h1FF;
    settle();
    chk_irq(1'b1, 16'h0080, 4'hB);
    @(posedge clk);
    flg[0] <= 1'b0;
    settle();
    chk_irq(1'b1, 16'h0084, 4'hB);
    @(posedge clk);
    flg <= 10'h100;
    settle();
    chk_irq(1'b1, 16'h00AC, 4'hB);
    clr();
  endtask
  task automatic t_soft();
    for (int k = 1; k < 8; k++) begin
      wr(evi_pkg::OFF_SWR, 8'h01 << k);
      settle();
      chk_irq(1'b0, 16'h0000, 4'h0);
      wr(evi_pkg::OFF_SWE, 8'h01 << k);
      settle();
      chk_irq(1'b1, evi_pkg::VEC[8 + k], 4'(k));
    end
    clr();
  endtask
  task automatic t_core();
    int n;
    ev_on(1, 3'h5);
    flg[1] <= 1'b1;
    settle();
    rd(evi_pkg::OFF_STAT);
    chk_reg(8'h8D);
    take_lat <= 2'h2;
    take_en  <= 1'b1;
    n = 0;
    while (irq_req === 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 20) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, irq_req, 1'b0);
      return;
    end
    take_en <= 1'b0;
    settle();
    chk_irq(1'b0, 16'h0000, 4'h0);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    settle();
    chk_irq(1'b1, 16'h0084, 4'hD);
    clr();
  endtask

  task automatic t_reset();
    ev_on(0, 3'h7);
    flg[0] <= 1'b1;
    wr(evi_pkg::OFF_SWE, 8'hFE);
    wr(evi_pkg::OFF_SWR, 8'hFE);
    settle();
    chk_irq(1'b1, 16'h0080, 4'hF);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    chk_irq(1'b0, 16'h0000, 4'h0);
    for (int a = 0; a < 10; a++) begin
      rd(4'(a));
      chk_reg(8'h00);
    end
    clr();
  endtask

  task automatic final_report();
    $display("Mismatches %0d of %0d compares", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    sys_rst   = 1'b1;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
    take_en   = 1'b0;
    ret       = 1'b0;
    take_lat  = 2'h0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    flg       = 10'h000;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    t_regs();
    t_events();
    t_gate();
    t_tie();
    t_soft();
    t_core();
    t_reset();
    final_report();
  end
endmodule // evi_ctrl_bench
